// >>> rtl/fsq_sequencer.sv
// Flash command sequencer: block erase, program, status register and error
// flags, behind a classic Wishbone slave. Assumes the CPU issues one byte
// per command cycle to the user ROM window and waits for ack.
//
// Design decisions made here: the address map and the Wishbone interface to the registers.

`default_nettype none

module fsq_sequencer #(
	parameter int BLOCKS = fsq_pkg::FLASH_BLOCKS,
	parameter int BLOCK_BYTES = fsq_pkg::FLASH_BLOCK_BYTES,
	parameter int PROG_CYCLES = fsq_pkg::PROG_CYCLES
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic seq_ready_o
);

	localparam int BAW = $clog2(BLOCK_BYTES);
	localparam int BLW = (BLOCKS > 1) ? $clog2(BLOCKS) : 1;
	localparam int FAW = BAW + BLW;
	localparam int FLASH_BYTES = BLOCKS * BLOCK_BYTES;

	////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		fsq_pkg::fsq_state_t st;
		logic ack;
		logic [31:0] dat;
		logic ready;
		logic ew1;
		logic rewrite_enable;
		logic fault_inject;
		logic block0_lock;
		logic block1_lock;
		logic program_error_flag;
		logic erase_error_flag;
		logic stat_mode;
		logic pend_erase;
		logic pend_prog;
		logic [11:0] pend_addr;
		logic [BLW-1:0] op_blk;
		logic [BAW-1:0] idx;
		logic [FAW-1:0] op_addr;
		logic [7:0] op_data;
	} fsq_seq_t;

	fsq_seq_t r, n;

	logic req;
	logic rom_hit;
	logic byte_wr;
	logic [11:0] rom_off;
	logic in_flash;
	logic [BLW-1:0] tgt_blk;
	logic blk_locked;
	logic err_any;
	logic [7:0] cbyte;
	logic [7:0] status_byte;
	logic [7:0] rd_byte;
	logic [7:0] mem_rdata;
	logic [7:0] mem_vdata;
	logic mem_we;
	logic [FAW-1:0] mem_waddr;
	logic [7:0] mem_wdata;
	logic [FAW-1:0] mem_vaddr;
	logic prog_start;
	logic prog_done;
	logic cmd_wr;
	logic last_idx;
	logic [FAW-1:0] erase_addr;
	logic [7:0] ctrl_image;
	logic [7:0] prot_image;

	////////////////////////////////////////////////////////////////////////
	// Address decode and command byte.

	assign req = wb_cyc_i & wb_stb_i & ~r.ack;
	assign rom_hit = (wb_adr_i[15:12] == fsq_pkg::ROM_AREA);
	assign rom_off = wb_adr_i[11:0];
	assign byte_wr = (wb_sel_i == (4'h1 << wb_adr_i[1:0]));
	assign cbyte = wb_dat_i[{wb_adr_i[1:0], 3'b000} +: 8];
	// The ROM window is wider than the array; the excess reads as erased
	// and an erase confirm or program data cycle aimed there is a sequence error.
	assign in_flash = (32'(rom_off) < 32'(FLASH_BYTES));
	assign tgt_blk = rom_off[BAW +: BLW];
	assign err_any = r.program_error_flag | r.erase_error_flag;
	assign cmd_wr = wb_we_i & byte_wr & (r.st == fsq_pkg::FSQ_IDLE);
	assign last_idx = (r.idx == BAW'(BLOCK_BYTES - 1));
	assign erase_addr = {r.op_blk, r.idx};

	// Only blocks 0 and 1 carry lock bits; the others are always open.
	always_comb begin
		blk_locked = 1'b0;
		if (tgt_blk == BLW'(0)) begin
			blk_locked = ~r.rewrite_enable | r.block0_lock;
		end else if (tgt_blk == BLW'(1)) begin
			blk_locked = r.block1_lock;
		end
	end

	// Reserved positions stay zero.
	always_comb begin
		status_byte = 8'h00;
		status_byte[fsq_pkg::SR_READY_BIT] = r.ready;
		status_byte[fsq_pkg::SR_ERASE_BIT] = r.erase_error_flag;
		status_byte[fsq_pkg::SR_PROG_BIT] = r.program_error_flag;
	end

	always_comb begin
		if (r.stat_mode) begin
			rd_byte = status_byte;
		end else if (in_flash) begin
			rd_byte = mem_rdata;
		end else begin
			rd_byte = fsq_pkg::ERASED_BYTE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register images. Unused bit positions read as zero.

	always_comb begin
		ctrl_image = 8'h00;
		ctrl_image[fsq_pkg::CTRL_READY_BIT] = r.ready;
		ctrl_image[fsq_pkg::CTRL_EW1_BIT] = r.ew1;
		ctrl_image[fsq_pkg::CTRL_REWRITE_BIT] = r.rewrite_enable;
		ctrl_image[fsq_pkg::CTRL_FAULT_BIT] = r.fault_inject;
		ctrl_image[fsq_pkg::CTRL_PERR_BIT] = r.program_error_flag;
		ctrl_image[fsq_pkg::CTRL_EERR_BIT] = r.erase_error_flag;
	end

	always_comb begin
		prot_image = 8'h00;
		prot_image[fsq_pkg::PROT_B0_BIT] = r.block0_lock;
		prot_image[fsq_pkg::PROT_B1_BIT] = r.block1_lock;
	end

	////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		n = r;
		n.ack = 1'b0;
		prog_start = 1'b0;
		mem_we = 1'b0;
		mem_waddr = r.op_addr;
		mem_wdata = r.op_data;
		mem_vaddr = r.op_addr;

		if (req) begin
			n.ack = 1'b1;
			n.dat = 32'h0000_0000;
			if (rom_hit) begin
				if (!wb_we_i) begin
					n.dat = {4{rd_byte}};
				// A write while the sequencer is busy is dropped; reads follow the read
				// mode, which the operation switches to status only while ew1 is clear.
				end else if (cmd_wr) begin
					if (r.pend_erase) begin
						n.pend_erase = 1'b0;
						if (cbyte == fsq_pkg::CMD_ERASE_CONFIRM) begin
							if (!in_flash || blk_locked) begin
								n.erase_error_flag = 1'b1;
								n.program_error_flag = 1'b1;
							end else begin
								n.st = fsq_pkg::FSQ_ERASE;
								n.ready = 1'b0;
								n.op_blk = tgt_blk;
								n.idx = '0;
								if (!r.ew1) begin
									n.stat_mode = 1'b1;
								end
							end
						end else if (cbyte == fsq_pkg::CMD_READ_ARRAY) begin
							n.stat_mode = 1'b0;
						end else begin
							n.erase_error_flag = 1'b1;
							n.program_error_flag = 1'b1;
						end
					end else if (r.pend_prog) begin
						n.pend_prog = 1'b0;
						// The data cycle must repeat the setup address.
						if (rom_off != r.pend_addr || !in_flash ||
								blk_locked) begin
							n.erase_error_flag = 1'b1;
							n.program_error_flag = 1'b1;
						end else begin
							n.st = fsq_pkg::FSQ_PROG;
							n.ready = 1'b0;
							n.op_addr = rom_off[FAW-1:0];
							n.op_data = cbyte;
							prog_start = 1'b1;
							if (!r.ew1) begin
								n.stat_mode = 1'b1;
							end
						end
					end else begin
						case (cbyte)
							fsq_pkg::CMD_READ_ARRAY: begin
								n.stat_mode = 1'b0;
							end
							fsq_pkg::CMD_READ_STATUS: begin
								n.stat_mode = 1'b1;
							end
							fsq_pkg::CMD_CLEAR_STATUS: begin
								n.erase_error_flag = 1'b0;
								n.program_error_flag = 1'b0;
							end
							fsq_pkg::CMD_ERASE_SETUP: begin
								n.pend_erase = ~err_any;
							end
							fsq_pkg::CMD_PROGRAM: begin
								n.pend_prog = ~err_any;
								n.pend_addr = rom_off;
							end
							default: begin
								n.erase_error_flag = 1'b1;
								n.program_error_flag = 1'b1;
							end
						endcase
					end
				end
			end else if (wb_adr_i == fsq_pkg::ADR_CTRL) begin
				if (wb_we_i) begin
					if (wb_sel_i[0]) begin
						n.ew1 = wb_dat_i[fsq_pkg::CTRL_EW1_BIT];
						n.rewrite_enable =
							wb_dat_i[fsq_pkg::CTRL_REWRITE_BIT];
						n.fault_inject = wb_dat_i[fsq_pkg::CTRL_FAULT_BIT];
					end
				end else begin
					n.dat[7:0] = ctrl_image;
				end
			end else if (wb_adr_i == fsq_pkg::ADR_PROT) begin
				if (wb_we_i) begin
					if (wb_sel_i[0]) begin
						n.block0_lock = wb_dat_i[fsq_pkg::PROT_B0_BIT];
						n.block1_lock = wb_dat_i[fsq_pkg::PROT_B1_BIT];
					end
				end else begin
					n.dat[7:0] = prot_image;
				end
			end
		end

		// Operation engine. It runs after the bus decode so an error raised
		// by a finishing operation always lands, whatever the bus did.
		case (r.st)
			fsq_pkg::FSQ_IDLE: begin
			end
			fsq_pkg::FSQ_ERASE: begin
				mem_we = 1'b1;
				mem_waddr = erase_addr;
				mem_wdata = r.fault_inject ? 8'hFE : fsq_pkg::ERASED_BYTE;
				n.idx = r.idx + 1'b1;
				if (last_idx) begin
					n.st = fsq_pkg::FSQ_EVERIFY;
					n.idx = '0;
				end
			end
			fsq_pkg::FSQ_EVERIFY: begin
				mem_vaddr = erase_addr;
				n.idx = r.idx + 1'b1;
				if (mem_vdata != fsq_pkg::ERASED_BYTE) begin
					n.erase_error_flag = 1'b1;
				end
				if (last_idx) begin
					n.st = fsq_pkg::FSQ_IDLE;
					n.ready = 1'b1;
				end
			end
			fsq_pkg::FSQ_PROG: begin
				if (prog_done) begin
					mem_we = 1'b1;
					mem_wdata = r.fault_inject ? ~r.op_data : r.op_data;
					n.st = fsq_pkg::FSQ_PVERIFY;
				end
			end
			fsq_pkg::FSQ_PVERIFY: begin
				if (mem_vdata != r.op_data) begin
					n.program_error_flag = 1'b1;
				end
				n.st = fsq_pkg::FSQ_IDLE;
				n.ready = 1'b1;
			end
			default: begin
				n.st = fsq_pkg::FSQ_IDLE;
				n.ready = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
			r.st <= fsq_pkg::FSQ_IDLE;
			r.ready <= 1'b1;
		end else begin
			r <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Cell array and program timer.

	fsq_flash_array #(
		.DEPTH(1 << FAW),
		.AW(FAW)
	) u_array (
		.clk_sys_i(clk_sys_i),
		.we_i(mem_we),
		.waddr_i(mem_waddr),
		.wdata_i(mem_wdata),
		.raddr_i(rom_off[FAW-1:0]),
		.rdata_o(mem_rdata),
		.vaddr_i(mem_vaddr),
		.vdata_o(mem_vdata)
	);

	// Sixteen counter bits leave room for far longer program times.
	fsq_op_timer #(
		.COUNT(PROG_CYCLES),
		.W(16)
	) u_prog_timer (
		.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i),
		.start_i(prog_start),
		.done_o(prog_done)
	);

	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign seq_ready_o = r.ready;

endmodule

`default_nettype wire

// >>> rtl/fsq_pkg.sv
// Constants, state codes and register layout for the flash block erase and
// status sequencer. Assumes a 100 MHz system clock and a classic Wishbone
// slave port with 32-bit data and byte addresses.
//
// Behaviour
// - Setup 20h then confirm D0h inside a block starts erase and verify.
// - Ready flag reads 0 during the whole erase, then 1.
// - Block 0 erase ignored unless rewrite enabled and block 0 unlocked; the code skips it and sets both error flags.
// - Block 1 erase ignored while block 1 lock is 1; the code skips it and sets both error flags.
// - RAM-run mode enters status-read mode when the erase starts.
// - Status bit 7 falls at erase start, rises at erase end.
// - RAM-run mode stays in status-read mode until read array.
// - Status reads after read status, program or erase until read array; program and erase set status mode only while ew1 is clear.
// - Status byte: bit 4 program, bit 5 erase, bit 7 ready.
// - Sequencer bit is 0 while programming or erasing, 1 when done.
// - Clear status resets both error flags and their status images.
// - Either error flag set refuses new program and erase commands.
// - Command sequence errors set both error flags.
// - Failed erase sets erase error 1 and program error 0.
// - Failed program sets erase error 0 and program error 1.
// - Read array code as erase second cycle drops it, enters read array.
// - Read array code in a first cycle selects read array mode.
// - Read status code makes the following read return the status byte.
// - Clear status code in one cycle clears both error flags.

`default_nettype none

package fsq_pkg;

	localparam int CLK_PERIOD_NS = 10;
	localparam int PROG_TIME_NS = 1000;
	localparam int PROG_CYCLES =
		(PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int FLASH_BLOCKS = 4;
	localparam int FLASH_BLOCK_BYTES = 64;

	////////////////////////////////////////////////////////////////////////
	localparam logic [15:0] ADR_CTRL = 16'h0000;
	localparam logic [15:0] ADR_PROT = 16'h0004;
	localparam logic [3:0] ROM_AREA = 4'h1;

	localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
	localparam logic [7:0] CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
	localparam logic [7:0] CMD_PROGRAM = 8'h40;
	localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	localparam int CTRL_READY_BIT = 0;
	localparam int CTRL_EW1_BIT = 1;
	localparam int CTRL_REWRITE_BIT = 2;
	localparam int CTRL_FAULT_BIT = 3;
	localparam int CTRL_PERR_BIT = 6;
	localparam int CTRL_EERR_BIT = 7;
	localparam int PROT_B0_BIT = 0;
	localparam int PROT_B1_BIT = 1;

	localparam int SR_PROG_BIT = 4;
	localparam int SR_ERASE_BIT = 5;
	localparam int SR_READY_BIT = 7;

	typedef enum logic [4:0] {
		FSQ_IDLE = 5'b00001,
		FSQ_ERASE = 5'b00010,
		FSQ_EVERIFY = 5'b00100,
		FSQ_PROG = 5'b01000,
		FSQ_PVERIFY = 5'b10000
	} fsq_state_t;

endpackage

`default_nettype wire

// >>> rtl/fsq_flash_array.sv
// Byte-wide flash cell array with one write port and two read ports.
// Assumes the sequencer serialises all writes; contents are not reset.

`default_nettype none

module fsq_flash_array #(
	parameter int DEPTH = 256,
	parameter int AW = 8
) (
	input wire logic clk_sys_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [7:0] rdata_o,
	input wire logic [AW-1:0] vaddr_i,
	output logic [7:0] vdata_o
);

	// Reads are combinational so the bus answer and the verify compare both
	// see the cell in the same cycle; fine for the small array used here.
	logic [7:0] mem [DEPTH];

	always_ff @(posedge clk_sys_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	assign rdata_o = mem[raddr_i];
	assign vdata_o = mem[vaddr_i];

endmodule

`default_nettype wire

// >>> rtl/fsq_op_timer.sv
// Counts a fixed number of cycles after a start pulse and then pulses done.
// Assumes start is a one-cycle pulse issued only while the timer is idle.

`default_nettype none

module fsq_op_timer #(
	parameter int COUNT = 100,
	parameter int W = 8
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic start_i,
	output logic done_o
);

	typedef struct packed {
		logic run;
		logic done;
		logic [W-1:0] cnt;
	} fsq_tmr_t;

	fsq_tmr_t r, n;

	always_comb begin
		n = r;
		n.done = 1'b0;
		if (start_i) begin
			n.run = 1'b1;
			n.cnt = W'(COUNT - 1);
		end else if (r.run) begin
			if (r.cnt == '0) begin
				n.run = 1'b0;
				n.done = 1'b1;
			end else begin
				n.cnt = r.cnt - 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign done_o = r.done;

endmodule

`default_nettype wire

// >>> test/fsq_props.sv
// Checker for the flash sequencer bus port and its busy flag.
// Assumes it is bound to fsq_sequencer and sees only that module's ports.
`default_nettype none
module fsq_props #(
	parameter int BLOCK_BYTES = 64,
	parameter int PROG_CYCLES = 100
) (
	input wire logic clk_sys_i,
	input wire logic rstn_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [15:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic seq_ready_o
);
	// Erase is write plus verify of one block, so it bounds every busy span.
	localparam int MAXB = 2 * BLOCK_BYTES + 16;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);
	logic [8:0] busy_cnt_reg;
	logic req;
	logic rom;
	logic unm;
	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign rom = wb_adr_i[15:12] == 4'h1;
	assign unm = !rom && wb_adr_i != 16'h0000 && wb_adr_i != 16'h0004;
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i)
			busy_cnt_reg <= 9'h000;
		else if (seq_ready_o)
			busy_cnt_reg <= 9'h000;
		else
			busy_cnt_reg <= busy_cnt_reg + 9'h001;
	end
	////////////////////////////////////////////////////////////////////
	property p_ack_next;
		req |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
	property p_no_stray;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_no_stray: assert property (p_no_stray) else $error("stray ack");
	property p_hold;
		!wb_ack_o |-> $stable(wb_dat_o);
	endproperty
	a_hold: assert property (p_hold) else $error("data moved");
	property p_busy_cause;
		$fell(seq_ready_o) |-> wb_ack_o && $past(wb_we_i && rom);
	endproperty
	a_busy_cause: assert property (p_busy_cause) else $error("busy cause");
	property p_busy_max;
		busy_cnt_reg <= MAXB;
	endproperty
	a_busy_max: assert property (p_busy_max) else $error("busy long");
	property p_busy_min;
		$rose(seq_ready_o) |-> busy_cnt_reg >= PROG_CYCLES;
	endproperty
	a_busy_min: assert property (p_busy_min) else $error("busy short");
	property p_ctrl_rdy;
		wb_ack_o && $past(!wb_we_i && wb_adr_i == 16'h0000)
			|-> wb_dat_o[0] == $past(seq_ready_o);
	endproperty
	a_ctrl_rdy: assert property (p_ctrl_rdy) else $error("ready bit");
	property p_lanes;
		wb_ack_o && $past(!wb_we_i && rom) |-> wb_dat_o
			== {4{wb_dat_o[7:0]}};
	endproperty
	a_lanes: assert property (p_lanes) else $error("lanes differ");
	property p_unm;
		wb_ack_o && $past(!wb_we_i && unm) |-> wb_dat_o == 32'h0;
	endproperty
	a_unm: assert property (p_unm) else $error("unmapped data");
	c_busy: cover property ($fell(seq_ready_o));
	c_rom: cover property (wb_ack_o && $past(!wb_we_i && rom));
	c_unm: cover property (wb_ack_o && $past(unm));
endmodule
bind fsq_sequencer fsq_props #(.BLOCK_BYTES(BLOCK_BYTES),
	.PROG_CYCLES(PROG_CYCLES)) fsq_props_i (.clk_sys_i(clk_sys_i),
	.rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o), .seq_ready_o(seq_ready_o));
`default_nettype wire

// >>> test/fsq_cpu_model.sv
// Bus master model of the CPU core issuing byte-wide flash cycles.
// Assumes a classic Wishbone slave that answers with a one-cycle ack.
`default_nettype none
module fsq_cpu_model (
	input wire logic clk_sys_i,
	input wire logic wb_ack_i,
	input wire logic [31:0] wb_dat_i,
	output logic wb_cyc_o,
	output logic wb_stb_o,
	output logic wb_we_o,
	output logic [15:0] wb_adr_o,
	output logic [3:0] wb_sel_o,
	output logic [31:0] wb_dat_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		wb_cyc_o = 1'b0;
		wb_stb_o = 1'b0;
		wb_we_o = 1'b0;
		wb_adr_o = 16'h0000;
		wb_sel_o = 4'h0;
		wb_dat_o = 32'h0;
	end
	////////////////////////////////////////////////////////////////////
	// Only byte cycles on the lane of the address are issued.
	task automatic xfer(input logic we, input logic [15:0] a,
		input logic [7:0] d, output logic [31:0] q);
		@(posedge clk_sys_i);
		wb_cyc_o <= 1'b1;
		wb_stb_o <= 1'b1;
		wb_we_o <= we;
		wb_adr_o <= a;
		wb_sel_o <= 4'h1 << a[1:0];
		wb_dat_o <= {4{d}};
		// Ack is read at the rising edge, before this edge's updates land.
		do
			@(posedge clk_sys_i);
		while (wb_ack_i !== 1'b1);
		q = wb_dat_i;
		wb_cyc_o <= 1'b0;
		wb_stb_o <= 1'b0;
		// Released lines show garbage so stale values are never trusted.
		wb_adr_o <= ~a;
		wb_dat_o <= ~{4{d}};
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] q);
		xfer(1'b0, a, 8'h00, q);
	endtask
	// No suspend is ever issued and code never runs from flash.
	task automatic erase(input logic [15:0] a);
		wr(16'h1000, 8'h20);
		wr(a, 8'hD0);
	endtask
endmodule
`default_nettype wire

// >>> test/test_fsq_sequencer.sv
// Self-checking bench for the flash sequencer: erase, status and errors.
// Assumes the CPU model supplies bus cycles and the checker is bound.
`default_nettype none
module test_fsq_sequencer;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_i = 1'b0;
	logic rstn_i = 1'b0;
	logic cyc, stb, we, ack, rdy;
	logic [15:0] adr;
	logic [3:0] sel;
	logic [31:0] dw, dr;
	int miscompares = 0;
	int check_count = 0;
	logic [15:0] bad [3] = '{16'h1000, 16'h1040, 16'h1100};
	always #5 clk_sys_i = ~clk_sys_i;
	fsq_sequencer #(.PROG_CYCLES(4)) fsq_sequencer_i (.clk_sys_i(clk_sys_i),
		.rstn_i(rstn_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
		.wb_ack_o(ack), .seq_ready_o(rdy));
	fsq_cpu_model fsq_cpu_model_i (.clk_sys_i(clk_sys_i), .wb_ack_i(ack),
		.wb_dat_i(dr), .wb_cyc_o(cyc), .wb_stb_o(stb), .wb_we_o(we),
		.wb_adr_o(adr), .wb_sel_o(sel), .wb_dat_o(dw));
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] e, m);
		check_count++;
		if ((got & m) !== (e & m)) begin
			miscompares++;
			$display("[FAIL] %0t got %h exp %h", $time, got, e);
		end
	endtask
	task automatic rd(input logic [15:0] a, input logic [31:0] e, m);
		logic [31:0] q;
		fsq_cpu_model_i.rd(a, q);
		chk(q, e, m);
	endtask
	task automatic w(input logic [15:0] a, input logic [7:0] d);
		fsq_cpu_model_i.wr(a, d);
	endtask
	task automatic st(input logic [7:0] e);
		rd(16'h1000, {4{e}}, '1);
	endtask
	task automatic rdy_is(input logic e);
		@(negedge clk_sys_i);
		chk({31'h0, rdy}, {31'h0, e}, 32'h1);
	endtask
	// Erase is the longest operation, so a bounded poll is enough.
	task automatic wait_rdy;
		for (int i = 0; i < 400 && rdy !== 1'b1; i++)
			@(negedge clk_sys_i);
		chk({31'h0, rdy}, 32'h1, 32'h1);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#200000;
		miscompares++;
		test_done();
	end
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rstn_i <= 1'b1;
		rd(16'h0000, 32'h01, 32'hFF);
		rd(16'h0100, 32'h0, '1);
		w(16'h1000, 8'h70);
		st(8'h80);
		fsq_cpu_model_i.erase(16'h1000);
		rdy_is(1'b1);
		rd(16'h0000, 32'hC1, 32'hFF);
		w(16'h1000, 8'h70);
		st(8'hB0);
		fsq_cpu_model_i.erase(16'h1080);
		rdy_is(1'b1);
		w(16'h1000, 8'h50);
		rd(16'h0000, 32'h01, 32'hFF);
		w(16'h0000, 8'h04);
		fsq_cpu_model_i.erase(16'h1080);
		rdy_is(1'b0);
		rd(16'h0000, 32'h0, 32'h1);
		st(8'h00);
		wait_rdy();
		st(8'h80);
		w(16'h1000, 8'hFF);
		rd(16'h10BF, '1, '1);
		w(16'h1000, 8'h20);
		w(16'h1080, 8'hFF);
		rd(16'h1081, '1, '1);
		rd(16'h0000, 32'h05, 32'hFF);
		w(16'h1000, 8'h20);
		w(16'h1080, 8'h55);
		rd(16'h0000, 32'hC5, 32'hFF);
		w(16'h1000, 8'h50);
		w(16'h0004, 8'h03);
		foreach (bad[i]) begin
			fsq_cpu_model_i.erase(bad[i]);
			rdy_is(1'b1);
			rd(16'h0000, 32'hC5, 32'hFF);
			w(16'h1000, 8'h50);
		end
		w(16'h0000, 8'h0C);
		fsq_cpu_model_i.erase(16'h10C0);
		wait_rdy();
		rd(16'h0000, 32'h81, 32'hC1);
		st(8'hA0);
		w(16'h1000, 8'h50);
		w(16'h0000, 8'h0C);
		w(16'h10C0, 8'h40);
		w(16'h10C0, 8'h5A);
		wait_rdy();
		rd(16'h0000, 32'h41, 32'hC1);
		w(16'h1000, 8'h50);
		w(16'h0000, 8'h04);
		w(16'h10C1, 8'h40);
		w(16'h10C1, 8'h5A);
		rdy_is(1'b0);
		wait_rdy();
		w(16'h1000, 8'hFF);
		rd(16'h10C1, 32'h5A5A_5A5A, '1);
		w(16'h0000, 8'h06);
		fsq_cpu_model_i.erase(16'h1080);
		rdy_is(1'b0);
		rd(16'h10C1, 32'h5A5A_5A5A, '1);
		wait_rdy();
		rd(16'h1080, '1, '1);
		test_done();
	end
endmodule
`default_nettype wire
